// file: include/bsio_pkg.sv
// Constants and types shared by the beam switching I/O stage.
// Function
// [R1] Cascade trigger input and output stay inactive unless cascading is on.
// [R2] Executing teach height on a pin sets its function to area output.
// [R3] Each output has a polarity bit; inverted complements the output level.
// [R4] Results update only after beams stay identical for filter-depth cycles.
// [R5] Filter depth accepts up to 255; larger entries are rejected.
// [R6] Polarity and filter depth are writable from the fieldbus port too.
// [R7] Function selector: trigger/teach in, area/warn/trigger/validation out.
// [R8] Start and end beam accept up to 1774; larger entries are rejected.
// [R9] OR area output is on when any beam in range is interrupted.
// [R10] Stability count restarts when the beam pattern changes.
package bsio_pkg;
  localparam int NPIN = 3;
  localparam int BEAM_W = 11;
  localparam int DEPTH_W = 8;
  localparam int DATA_W = 11;
  localparam logic [BEAM_W-1:0] BEAM_MAX = 11'h6EE;
  localparam logic [DATA_W-1:0] DEPTH_MAX = 11'h0FF;
  localparam logic [DEPTH_W-1:0] CNT_SAT = 8'hFF;
  localparam int NBEAM = 1775;

  typedef enum logic [2:0] {
    FN_TRIG_IN = 3'h0,
    FN_TEACH_IN = 3'h1,
    FN_AREA_OUT = 3'h2,
    FN_WARN_OUT = 3'h3,
    FN_TRIG_OUT = 3'h4,
    FN_VALID_OUT = 3'h5
  } bsio_func_t;

  typedef enum logic [2:0] {
    IT_FUNC = 3'h0,
    IT_INV = 3'h1,
    IT_LOGIC = 3'h2,
    IT_START = 3'h3,
    IT_END = 3'h4,
    IT_DEPTH = 3'h5,
    IT_CASC = 3'h6,
    IT_TEACH = 3'h7
  } bsio_item_t;

  localparam logic [2:0] RST_FUNC = 3'h2;
  localparam logic RST_INV = 1'h0;
  localparam logic RST_LOGIC_OR = 1'h1;
  localparam logic [BEAM_W-1:0] RST_START = 11'h001;
  localparam logic [BEAM_W-1:0] RST_END = 11'h001;
  localparam logic [DEPTH_W-1:0] RST_DEPTH = 8'h01;
  localparam logic RST_CASC = 1'h0;
endpackage : bsio_pkg

// file: verilog/bsio_pin_stage.sv
// Output and input stage of one configurable I/O pin.
`timescale 1ns/1ps
module bsio_pin_stage (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] func,
  input wire logic invert,
  input wire logic casc_en,
  input wire logic area_res,
  input wire logic warn,
  input wire logic trig_src,
  input wire logic valid,
  input wire logic pin_sync,
  output logic pin_out_q,
  output logic pin_oe_q,
  output logic trig_in_q,
  output logic teach_in_q
);
  import bsio_pkg::*;

  logic src;
  logic drive;

  always_comb begin
    src = 1'b0;
    drive = 1'b0;
    case (func)
      FN_AREA_OUT: begin
        src = area_res;
        drive = 1'b1;
      end
      FN_WARN_OUT: begin
        src = warn;
        drive = 1'b1;
      end
      FN_TRIG_OUT: begin
        src = trig_src;
        drive = casc_en; // [R1]
      end
      FN_VALID_OUT: begin
        src = valid;
        drive = 1'b1;
      end
      default: begin
        src = 1'b0;
        drive = 1'b0;
      end
    endcase
  end

  // An undriven pin holds a low output so the wire level is defined.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_out_q <= drive & (src ^ invert); // [R3]
      pin_oe_q <= drive;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trig_in_q <= 1'b0;
      teach_in_q <= 1'b0;
    end else begin
      trig_in_q <= casc_en & (func == FN_TRIG_IN) & pin_sync; // [R1]
      teach_in_q <= (func == FN_TEACH_IN) & pin_sync;
    end
  end

  a_trig_gated: assert property ( // [R1]
    @(posedge clock) disable iff (!rst_n)
    !casc_en |=> !trig_in_q && !($past(func == FN_TRIG_OUT) && pin_oe_q))
    else $error("trigger pin active while cascading is off");

  a_out_polarity: assert property ( // [R3]
    @(posedge clock) disable iff (!rst_n)
    (func == FN_AREA_OUT) |=> pin_oe_q && (pin_out_q == ($past(area_res)
      ^ $past(invert))))
    else $error("area output level does not follow polarity");
endmodule : bsio_pin_stage

// file: verilog/bsio_top.sv
// Beam switching I/O configuration, filtering and area evaluation.
`timescale 1ns/1ps
module bsio_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic panel_wr,
  input wire logic [1:0] panel_pin,
  input wire logic [2:0] panel_item,
  input wire logic [bsio_pkg::DATA_W-1:0] panel_data,
  input wire logic bus_wr,
  input wire logic [1:0] bus_pin,
  input wire logic [2:0] bus_item,
  input wire logic [bsio_pkg::DATA_W-1:0] bus_data,
  input wire logic beam_valid,
  input wire logic [bsio_pkg::BEAM_W-1:0] beam_idx,
  input wire logic beam_blk,
  input wire logic frame_end,
  input wire logic warn,
  input wire logic trig_src,
  input wire logic [bsio_pkg::NPIN-1:0] pin_in,
  output logic [bsio_pkg::NPIN-1:0] pin_out_q,
  output logic [bsio_pkg::NPIN-1:0] pin_oe_q,
  output logic [bsio_pkg::NPIN-1:0] trig_in_q,
  output logic [bsio_pkg::NPIN-1:0] teach_in_q,
  output logic cfg_reject_q,
  output logic cfg_ack_q,
  output logic casc_en_q,
  output logic [bsio_pkg::DEPTH_W-1:0] stable_cnt_q,
  output logic [bsio_pkg::NPIN-1:0] area_res_q,
  output logic valid_q
);
  import bsio_pkg::*;

  function automatic logic in_range(input logic [BEAM_W-1:0] idx,
                                    input logic [BEAM_W-1:0] a,
                                    input logic [BEAM_W-1:0] b);
    logic [BEAM_W-1:0] lo;
    logic [BEAM_W-1:0] hi;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    return (idx >= lo) && (idx <= hi);
  endfunction : in_range

  logic [NPIN-1:0][2:0] func_q;
  logic [NPIN-1:0] inv_q;
  logic [NPIN-1:0] or_logic_q;
  logic [NPIN-1:0][BEAM_W-1:0] start_q;
  logic [NPIN-1:0][BEAM_W-1:0] end_q;
  logic [DEPTH_W-1:0] depth_q;
  logic [NPIN-1:0] sync1_q;
  logic [NPIN-1:0] sync2_q;
  logic prev_mem [0:NBEAM-1];
  logic diff_q;
  logic [NPIN-1:0] any_q;
  logic [NPIN-1:0] all_q;
  logic [NPIN-1:0] seen_q;

  // Panel entries win over a fieldbus entry in the same cycle.
  logic wr;
  logic [1:0] wpin;
  logic [2:0] witem;
  logic [DATA_W-1:0] wdata;
  logic wok;
  logic wpin_ok;

  always_comb begin
    wr = panel_wr | bus_wr; // [R6]
    wpin = panel_wr ? panel_pin : bus_pin;
    witem = panel_wr ? panel_item : bus_item;
    wdata = panel_wr ? panel_data : bus_data;
    wpin_ok = (wpin < 2'(NPIN));
    wok = 1'b1;
    case (witem)
      IT_FUNC: wok = wpin_ok && (wdata <= 11'(FN_VALID_OUT)); // [R7]
      IT_START, IT_END: wok = wpin_ok && (wdata <= BEAM_MAX); // [R8]
      IT_DEPTH: wok = (wdata <= DEPTH_MAX); // [R5]
      IT_CASC: wok = 1'b1;
      default: wok = wpin_ok;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cfg_reject_q <= 1'b0;
      cfg_ack_q <= 1'b0;
    end else begin
      cfg_reject_q <= wr & ~wok; // [R5] [R8]
      cfg_ack_q <= wr & wok;
    end
  end

  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_cfg
      logic hit;
      assign hit = wr && wok && (wpin == 2'(p));
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          func_q[p] <= RST_FUNC;
          inv_q[p] <= RST_INV;
          or_logic_q[p] <= RST_LOGIC_OR;
          start_q[p] <= RST_START;
          end_q[p] <= RST_END;
        end else if (hit) begin
          case (witem)
            IT_FUNC: func_q[p] <= wdata[2:0]; // [R7]
            IT_INV: inv_q[p] <= wdata[0]; // [R3] [R6]
            IT_LOGIC: or_logic_q[p] <= wdata[0];
            IT_START: start_q[p] <= wdata[BEAM_W-1:0]; // [R8]
            IT_END: end_q[p] <= wdata[BEAM_W-1:0]; // [R8]
            IT_TEACH: func_q[p] <= FN_AREA_OUT; // [R2]
            default: func_q[p] <= func_q[p];
          endcase
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      depth_q <= RST_DEPTH;
      casc_en_q <= RST_CASC;
    end else if (wr && wok) begin
      if (witem == IT_DEPTH) begin
        depth_q <= wdata[DEPTH_W-1:0]; // [R5] [R6]
      end
      if (witem == IT_CASC) begin
        casc_en_q <= wdata[0]; // [R1]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // The previous pattern is not reset; the first frame may count as changed.
  logic beat_ok;
  logic diff_now;
  assign beat_ok = beam_valid && (beam_idx <= BEAM_MAX);
  assign diff_now = diff_q | (beat_ok && (beam_blk != prev_mem[beam_idx]));

  always_ff @(posedge clock) begin
    if (beat_ok) begin
      prev_mem[beam_idx] <= beam_blk;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || frame_end) begin
      diff_q <= 1'b0;
    end else begin
      diff_q <= diff_now;
    end
  end

  logic [NPIN-1:0] any_now;
  logic [NPIN-1:0] all_now;
  logic [NPIN-1:0] seen_now;
  logic [DEPTH_W-1:0] cnt_d;
  logic eval;

  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      if (beat_ok && in_range(beam_idx, start_q[p], end_q[p])) begin
        any_now[p] = any_q[p] | beam_blk; // [R9]
        all_now[p] = all_q[p] & beam_blk;
        seen_now[p] = 1'b1;
      end else begin
        any_now[p] = any_q[p];
        all_now[p] = all_q[p];
        seen_now[p] = seen_q[p];
      end
    end
    if (diff_now) begin
      cnt_d = 8'h01; // [R10]
    end else if (stable_cnt_q != CNT_SAT) begin
      cnt_d = stable_cnt_q + 8'h01;
    end else begin
      cnt_d = stable_cnt_q;
    end
    eval = (cnt_d >= depth_q); // [R4]
  end

  always_ff @(posedge clock) begin
    if (!rst_n || frame_end) begin
      any_q <= '0;
      all_q <= '1;
      seen_q <= '0;
    end else begin
      any_q <= any_now;
      all_q <= all_now;
      seen_q <= seen_now;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stable_cnt_q <= '0;
    end else if (frame_end) begin
      stable_cnt_q <= cnt_d; // [R10]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      area_res_q <= '0;
      valid_q <= 1'b0;
    end else if (frame_end) begin
      valid_q <= eval;
      for (int p = 0; p < NPIN; p++) begin
        if (eval) begin // [R4]
          area_res_q[p] <= or_logic_q[p] ? any_now[p] // [R9]
                                         : (all_now[p] & seen_now[p]);
        end
      end
    end
  end

  generate
    for (genvar p = 0; p < NPIN; p++) begin : g_pin
      bsio_pin_stage u_stage (
        .clock(clock),
        .rst_n(rst_n),
        .func(func_q[p]),
        .invert(inv_q[p]),
        .casc_en(casc_en_q),
        .area_res(area_res_q[p]),
        .warn(warn),
        .trig_src(trig_src),
        .valid(valid_q),
        .pin_sync(sync2_q[p]),
        .pin_out_q(pin_out_q[p]),
        .pin_oe_q(pin_oe_q[p]),
        .trig_in_q(trig_in_q[p]),
        .teach_in_q(teach_in_q[p])
      );
    end
  endgenerate

  a_teach_area: assert property ( // [R2]
    @(posedge clock) disable iff (!rst_n)
    wr && witem == IT_TEACH && wpin == 2'h1 |=> func_q[1] == FN_AREA_OUT)
    else $error("teach height did not select area output");

  a_hold_filter: assert property ( // [R4]
    @(posedge clock) disable iff (!rst_n)
    !$stable(area_res_q) |-> $past(frame_end) && stable_cnt_q >= depth_q)
    else $error("area result changed before filter depth reached");

  a_depth_reject: assert property ( // [R5]
    @(posedge clock) disable iff (!rst_n)
    wr && witem == IT_DEPTH && wdata > DEPTH_MAX
      |=> cfg_reject_q && $stable(depth_q))
    else $error("oversized filter depth was accepted");

  a_bus_invert: assert property ( // [R6]
    @(posedge clock) disable iff (!rst_n)
    bus_wr && !panel_wr && bus_item == IT_INV && bus_pin == 2'h1
      |=> inv_q[1] == $past(bus_data[0]) ##1 ($past(func_q[1]) != FN_AREA_OUT
      || pin_out_q[1] == ($past(area_res_q[1]) ^ $past(inv_q[1]))))
    else $error("fieldbus polarity write not applied");

  a_func_legal: assert property ( // [R7]
    @(posedge clock) disable iff (!rst_n)
    func_q[2] <= FN_VALID_OUT)
    else $error("pin function outside the selector range");

  a_beam_reject: assert property ( // [R8]
    @(posedge clock) disable iff (!rst_n)
    wr && witem == IT_START && wdata > 11'(BEAM_MAX)
      |=> cfg_reject_q && $stable(start_q))
    else $error("oversized start beam was accepted");

  a_or_area: assert property ( // [R9]
    @(posedge clock) disable iff (!rst_n)
    frame_end && eval && or_logic_q[0]
      |=> area_res_q[0] == $past(any_now[0]))
    else $error("OR area result wrong");

  a_cnt_restart: assert property ( // [R10]
    @(posedge clock) disable iff (!rst_n)
    frame_end && diff_now |=> stable_cnt_q == 8'h01)
    else $error("stability count did not restart on change");
endmodule : bsio_top

// file: verif/bsio_plc_model.sv
// Controller model that resolves the pin wires it shares with the stage.
`timescale 1ns/1ps
module bsio_plc_model (
  input wire logic [bsio_pkg::NPIN-1:0] pin_out_q,
  input wire logic [bsio_pkg::NPIN-1:0] pin_oe_q,
  input wire logic [bsio_pkg::NPIN-1:0] drv_en,
  input wire logic [bsio_pkg::NPIN-1:0] drv_val,
  output logic [bsio_pkg::NPIN-1:0] pin_level
);
  import bsio_pkg::*;
  // A released line falls to the pull-down level of a PNP input, so a
  // stale high can never pass for a driven one.
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_level[i] = pin_oe_q[i] ? pin_out_q[i] : (drv_en[i] & drv_val[i]);
    end
  end
endmodule : bsio_plc_model

// file: verif/bsio_tb.sv
// Self-checking bench for the beam switching I/O stage.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  fail_count++; $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
module testbench;
  import bsio_pkg::*;
  logic clock, rst_n, panel_wr, bus_wr, beam_valid, beam_blk, frame_end;
  logic [1:0] panel_pin, bus_pin;
  logic [2:0] panel_item, bus_item;
  logic [DATA_W-1:0] panel_data, bus_data;
  logic [BEAM_W-1:0] beam_idx;
  logic [NPIN-1:0] pin_in, pin_out_q, pin_oe_q, trig_in_q, teach_in_q;
  logic [NPIN-1:0] area_res_q, drv_en, drv_val;
  logic cfg_reject_q, cfg_ack_q, casc_en_q, valid_q;
  logic warn, trig_src;
  logic [DEPTH_W-1:0] stable_cnt_q;
  int fail_count, n_compared;

  bsio_top dut (.clock, .rst_n, .panel_wr, .panel_pin, .panel_item,
    .panel_data, .bus_wr, .bus_pin, .bus_item, .bus_data, .beam_valid,
    .beam_idx, .beam_blk, .frame_end, .warn, .trig_src,
    .pin_in, .pin_out_q, .pin_oe_q, .trig_in_q, .teach_in_q, .cfg_reject_q,
    .cfg_ack_q, .casc_en_q, .stable_cnt_q, .area_res_q, .valid_q);

  bsio_plc_model plc (.pin_out_q, .pin_oe_q, .drv_en, .drv_val,
    .pin_level(pin_in));

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Both sources get the same fields; only the strobe picks the port.
  task automatic cfg(input logic src, input logic [1:0] pin,
      input logic [2:0] item, input logic [10:0] data, input logic ok);
    panel_pin = pin;
    bus_pin = pin;
    panel_item = item;
    bus_item = item;
    panel_data = data;
    bus_data = data;
    panel_wr = !src;
    bus_wr = src;
    @(posedge clock);
    #1;
    panel_wr = 0;
    bus_wr = 0;
    `CHK("ack", ok, cfg_ack_q)
    `CHK("reject", !ok, cfg_reject_q)
    @(posedge clock);
    #1;
  endtask : cfg

  task automatic frame(input logic [3:0] blk);
    for (int i = 1; i <= 4; i++) begin
      beam_valid = 1;
      beam_idx = 11'(i);
      beam_blk = blk[i-1];
      frame_end = (i == 4);
      @(posedge clock);
      #1;
    end
    beam_valid = 0;
    frame_end = 0;
    @(posedge clock);
    #1;
  endtask : frame

  task automatic chk_frame(input logic [3:0] blk, input logic [7:0] cnt,
      input logic area);
    frame(blk);
    `CHK("cnt", cnt, stable_cnt_q)
    `CHK("area", area, area_res_q[0])
    `CHK("valid", cnt >= 8'h03, valid_q)
  endtask : chk_frame

  task automatic t_reset;
    `CHK("oe_rst", 3'h0, pin_oe_q)
    `CHK("out", 3'h0, pin_out_q)
    `CHK("casc", 1'b0, casc_en_q)
    @(posedge clock);
    #1;
    `CHK("oe", 3'h7, pin_oe_q)
  endtask : t_reset

  task automatic t_limits;
    cfg(0, 0, IT_DEPTH, 11'h0FF, 1);
    cfg(1, 0, IT_DEPTH, 11'h100, 0);
    cfg(0, 0, IT_DEPTH, 11'h12B, 0);
    cfg(0, 0, IT_START, 11'h6EE, 1);
    cfg(1, 0, IT_START, 11'h6EF, 0);
    cfg(0, 3, IT_INV, 11'h001, 0);
    cfg(1, 0, IT_END, 11'h6EF, 0);
    cfg(0, 0, IT_END, 11'h7CF, 0);
    for (int f = 0; f < 6; f++) cfg(0, 2, IT_FUNC, 11'(f), 1);
    cfg(0, 2, IT_FUNC, 11'h006, 0);
  endtask : t_limits

  // Beam memory has no reset, so two quiet frames settle it first.
  task automatic t_filter;
    cfg(0, 0, IT_START, 11'h001, 1);
    cfg(0, 0, IT_END, 11'h004, 1);
    cfg(1, 0, IT_DEPTH, 11'h003, 1);
    cfg(0, 1, IT_START, 11'h002, 1);
    cfg(0, 1, IT_END, 11'h002, 1);
    cfg(0, 1, IT_LOGIC, 11'h000, 1);
    frame(4'h0);
    frame(4'h0);
    chk_frame(4'h2, 8'h01, 0);
    chk_frame(4'h2, 8'h02, 0);
    chk_frame(4'h2, 8'h03, 1);
    `CHK("and_on", 1'b1, area_res_q[1])
    @(posedge clock);
    #1;
    `CHK("pin_on", 1'b1, pin_out_q[0])
    chk_frame(4'h0, 8'h01, 1);
    chk_frame(4'h0, 8'h02, 1);
    chk_frame(4'h0, 8'h03, 0);
    `CHK("and_off", 1'b0, area_res_q[1])
  endtask : t_filter

  task automatic t_invert;
    cfg(1, 0, IT_INV, 11'h001, 1);
    cfg(1, 1, IT_INV, 11'h001, 1);
    @(posedge clock);
    #1;
    `CHK("inv_out", 1'b1, pin_out_q[0])
    `CHK("inv_out1", 1'b1, pin_out_q[1])
  endtask : t_invert

  task automatic t_teach;
    cfg(0, 1, IT_FUNC, 11'h001, 1);
    drv_en = 3'h2;
    drv_val = 3'h2;
    repeat (4) @(posedge clock);
    #1;
    `CHK("teach_oe", 1'b0, pin_oe_q[1])
    `CHK("teach_in", 1'b1, teach_in_q[1])
    cfg(0, 1, IT_TEACH, 11'h000, 1);
    drv_en = 3'h0;
    @(posedge clock);
    #1;
    `CHK("area_oe", 1'b1, pin_oe_q[1])
    `CHK("teach_gone", 1'b0, teach_in_q[1])
  endtask : t_teach

  task automatic t_cascade;
    trig_src = 1;
    cfg(0, 2, IT_FUNC, 11'h004, 1);
    `CHK("trig_out_off", 1'b0, pin_oe_q[2])
    cfg(0, 2, IT_FUNC, 11'h000, 1);
    drv_en = 3'h4;
    drv_val = 3'h4;
    repeat (4) @(posedge clock);
    #1;
    `CHK("trig_off", 1'b0, trig_in_q[2])
    cfg(1, 2, IT_CASC, 11'h001, 1);
    repeat (2) @(posedge clock);
    #1;
    `CHK("casc_on", 1'b1, casc_en_q)
    `CHK("trig_on", 1'b1, trig_in_q[2])
    drv_en = 3'h0;
    cfg(0, 2, IT_FUNC, 11'h004, 1);
    `CHK("trig_out_oe", 1'b1, pin_oe_q[2])
    `CHK("trig_out", 1'b1, pin_out_q[2])
    cfg(0, 2, IT_FUNC, 11'h003, 1);
    `CHK("warn_out", 1'b0, pin_out_q[2])
    cfg(0, 2, IT_FUNC, 11'h005, 1);
    `CHK("valid_out", 1'b1, pin_out_q[2])
  endtask : t_cascade

  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end

  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    give_verdict();
  end

  initial begin
    {rst_n, panel_wr, bus_wr, beam_valid, beam_blk, frame_end} = '0;
    {panel_pin, bus_pin, panel_item, bus_item} = '0;
    {panel_data, bus_data, beam_idx, drv_en, drv_val} = '0;
    {warn, trig_src} = '0;
    fail_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1;
    t_reset();
    t_limits();
    t_filter();
    t_invert();
    t_teach();
    t_cascade();
    give_verdict();
  end
endmodule : testbench
